// [hw/dyc_cfg.svh]
`ifndef DYC_CFG_SVH
`define DYC_CFG_SVH

// Register indices; the byte address on the bus is four times the index
`define DYC_IDX_CTRL 12'h114
`define DYC_IDX_SLOPE 12'h116
`define DYC_IDX_KNEE1 12'h117
`define DYC_IDX_KNEE2 12'h118
`define DYC_IDX_STAT 12'h119

// Control register fields
`define DYC_CTRL_ENA 0
`define DYC_CTRL_PATH 1
`define DYC_CTRL_K2OUT 4
`define DYC_CTRL_GATE 7
`define DYC_CTRL_MASK 16'h0093
`define DYC_CTRL_RST 16'h0000

// Slope register fields
`define DYC_SLOPE_LO 2:0
`define DYC_SLOPE_HI 5:3
`define DYC_SLOPE_EXP 7:6
`define DYC_SLOPE_MASK 16'h00FF
`define DYC_SLOPE_RST 16'h0018

// Knee register fields
`define DYC_KNEE1_IN 10:5
`define DYC_KNEE1_OUT 4:0
`define DYC_KNEE1_MASK 16'h07FF
`define DYC_KNEE2_IN 9:5
`define DYC_KNEE2_OUT 4:0
`define DYC_KNEE2_MASK 16'h03FF
`define DYC_KNEE_RST 16'h0000

// Slope codes that mean a flat (zero) slope
`define DYC_HI_ZERO_CODE 3'h5
`define DYC_LO_ZERO_CODE 3'h4

// Levels are attenuation below full scale in 0.75 dB units
`define DYC_K2_IN_BASE 12'h030
`define DYC_K2_OUT_BASE 12'h028
`define DYC_LEVEL_FLOOR 8'h7F
`define DYC_LOG_TOP 12'h078

// Mean-square averaging: one part in 2**shift per sample
`define DYC_AVG_SHIFT 6

// Gain mantissa 2**(k/8) in Q1.14, entry k at bits 16k+15:16k
`define DYC_MANT_TABLE 128'h7560_6BA2_62B4_5A82_52FF_4C1C_45CB_4000
`define DYC_MANT_FRAC 14
`define DYC_GAIN_MIN 12'hF40
`define DYC_GAIN_MAX 12'h03F

`define DYC_RESP_OKAY 2'h0
`define DYC_RESP_SLVERR 2'h2

`endif

// [hw/dyc_pkg.sv]
package dyc_pkg;
  typedef logic signed [23:0] dyc_sample_t;
  typedef logic [7:0] dyc_level_t;
  typedef logic signed [11:0] dyc_gain_t;
  typedef logic [2:0] dyc_slope_t;
endpackage

// [hw/dyc_level.sv]
`timescale 1ns/1ps
`include "dyc_cfg.svh"
module dyc_level
  import dyc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Sample stream of the selected path
  input wire logic smp_valid,
  input wire dyc_sample_t smp_l,
  input wire dyc_sample_t smp_r,
  // Averaged level
  output dyc_level_t level,
  output logic level_valid
);
  logic [14:0] mag_l;
  logic [14:0] mag_r;
  logic [14:0] peak;
  logic [29:0] sq;
  logic [29:0] ms_reg;
  logic [30:0] ms_sum;
  logic [4:0] lead;
  logic [29:0] norm;
  logic [11:0] atten;
  dyc_level_t level_reg;
  logic level_valid_reg;

  // Ones' complement avoids the overflow of negating the most negative code
  assign mag_l = smp_l[23] ? ~smp_l[22:8] : smp_l[22:8];
  assign mag_r = smp_r[23] ? ~smp_r[22:8] : smp_r[22:8];
  assign peak = (mag_l > mag_r) ? mag_l : mag_r;
  assign sq = peak * peak;
  assign ms_sum = {1'b0, ms_reg} + {1'b0, sq >> `DYC_AVG_SHIFT}
                  - {1'b0, ms_reg >> `DYC_AVG_SHIFT};

  // Stereo-linked running mean square, so the two channels keep one gain
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ms_reg <= 30'h0000_0000;
    end else if (smp_valid) begin
      ms_reg <= ms_sum[29:0];
    end
  end

  always_comb begin
    lead = 5'd0;
    for (int i = 0; i < 30; i++) begin
      if (ms_reg[i]) begin
        lead = 5'(i);
      end
    end
  end

  // Two bits below the leading one give the quarter steps of log2
  assign norm = ms_reg << (5'd29 - lead);
  assign atten = `DYC_LOG_TOP - {5'd0, lead, 2'b00} - {10'd0, norm[28:27]};

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level_reg <= `DYC_LEVEL_FLOOR;
      level_valid_reg <= 1'b0;
    end else begin
      level_valid_reg <= smp_valid;
      if (ms_reg == 30'h0000_0000) begin
        level_reg <= `DYC_LEVEL_FLOOR;
      end else begin
        level_reg <= atten[7:0];
      end
    end
  end

  assign level = level_reg;
  assign level_valid = level_valid_reg;
endmodule

// [hw/dyc_curve.sv]
`timescale 1ns/1ps
`include "dyc_cfg.svh"
module dyc_curve
  import dyc_pkg::*;
(
  // Measured level
  input wire dyc_level_t level_in,
  // Curve settings
  input wire logic [5:0] first_knee_in_level,
  input wire logic [4:0] first_knee_out_level,
  input wire dyc_slope_t upper_region_slope,
  input wire dyc_slope_t lower_region_slope,
  input wire logic [1:0] gate_expansion_slope,
  input wire logic [4:0] second_knee_in_level,
  input wire logic [4:0] second_knee_out_level,
  input wire logic noise_gate_enable,
  input wire logic second_knee_out_enable,
  // Results
  output dyc_gain_t gain,
  output logic [7:0] full_scale_out_level
);
  logic signed [11:0] a;
  logic signed [11:0] ki;
  logic signed [11:0] ko;
  logic signed [11:0] k2i;
  logic signed [11:0] k2_base;
  logic signed [11:0] b;
  logic signed [11:0] y0;

  // Reserved codes fall back to unity so a bad write never moves the gain
  function automatic logic signed [11:0] slope_apply(input logic signed [11:0] v,
                                                   input logic [2:0] code,
                                                   input logic [2:0] zero_code);
    if (code < zero_code) begin
      slope_apply = v >>> code;
    end else if (code == zero_code) begin
      slope_apply = 12'sh000;
    end else begin
      slope_apply = v;
    end
  endfunction

  assign a = {4'd0, level_in};
  assign ki = {6'd0, first_knee_in_level};
  assign ko = {7'd0, first_knee_out_level};
  assign k2i = `DYC_K2_IN_BASE + {6'd0, second_knee_in_level, 1'b0};

  always_comb begin
    if (second_knee_out_enable) begin
      k2_base = `DYC_K2_OUT_BASE + {6'd0, second_knee_out_level, 1'b0};
    end else begin
      k2_base = ko + slope_apply(k2i - ki, lower_region_slope, `DYC_LO_ZERO_CODE);
    end
  end

  // b is the output attenuation; a larger a means a quieter input
  always_comb begin
    if (a < ki) begin
      b = ko - slope_apply(ki - a, upper_region_slope, `DYC_HI_ZERO_CODE);
    end else if (noise_gate_enable && (a > k2i)) begin
      b = k2_base + ((a - k2i) <<< gate_expansion_slope);
    end else begin
      b = ko + slope_apply(a - ki, lower_region_slope, `DYC_LO_ZERO_CODE);
    end
  end

  assign gain = a - b;
  assign y0 = ko - slope_apply(ki, upper_region_slope, `DYC_HI_ZERO_CODE);
  assign full_scale_out_level = y0[7:0];
endmodule

// [hw/dyc_compressor.sv]
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dyc_cfg.svh"
module dyc_compressor
  import dyc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // AXI4-Lite write address
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Record path samples
  input wire logic rec_in_valid,
  input wire dyc_sample_t rec_in_l,
  input wire dyc_sample_t rec_in_r,
  output logic rec_out_valid,
  output dyc_sample_t rec_out_l,
  output dyc_sample_t rec_out_r,
  // Playback path samples
  input wire logic play_in_valid,
  input wire dyc_sample_t play_in_l,
  input wire dyc_sample_t play_in_r,
  output logic play_out_valid,
  output dyc_sample_t play_out_l,
  output dyc_sample_t play_out_r
);
  logic [15:0] ctrl_reg;
  logic [15:0] slope_reg;
  logic [15:0] knee1_reg;
  logic [15:0] knee2_reg;

  logic aw_held_reg;
  logic aw_held_next;
  logic [11:0] aw_idx_reg;
  logic w_held_reg;
  logic w_held_next;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic wr_fire;
  logic wr_hit;

  logic arready_reg;
  logic rvalid_reg;
  logic rvalid_next;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic rd_fire;
  logic [11:0] ar_idx;
  logic [31:0] rd_value;
  logic rd_hit;

  logic path_play;
  logic gain_on;
  logic det_valid;
  dyc_sample_t det_l;
  dyc_sample_t det_r;
  dyc_level_t level;
  logic level_valid;
  dyc_gain_t gain_raw;
  dyc_gain_t gain_clamped;
  logic [7:0] full_scale_out_level;

  logic [1:0] in_valid;
  logic [1:0] vld_d1_reg;
  logic [1:0] out_valid_reg;
  dyc_sample_t ch_in [4];
  dyc_sample_t ch_hold_reg [4];
  dyc_sample_t ch_out_reg [4];

  // Byte-lane merge of a 16-bit register, reserved bits forced to zero
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    merge = v & mask;
  endfunction

  // Write channel: address and data are taken in either order
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign aw_held_next = wr_fire ? 1'b0 : (aw_held_reg || (s_axi_awvalid && awready_reg));
  assign w_held_next = wr_fire ? 1'b0 : (w_held_reg || (s_axi_wvalid && wready_reg));
  assign wr_hit = (aw_idx_reg == `DYC_IDX_CTRL) || (aw_idx_reg == `DYC_IDX_SLOPE) ||
                  (aw_idx_reg == `DYC_IDX_KNEE1) || (aw_idx_reg == `DYC_IDX_KNEE2) ||
                  (aw_idx_reg == `DYC_IDX_STAT);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next;
      wready_reg <= !w_held_next;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      aw_idx_reg <= 12'h000;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        aw_idx_reg <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && wready_reg) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `DYC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? `DYC_RESP_OKAY : `DYC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Status is read-only; a write there is answered but changes nothing
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= `DYC_CTRL_RST;
      slope_reg <= `DYC_SLOPE_RST;
      knee1_reg <= `DYC_KNEE_RST;
      knee2_reg <= `DYC_KNEE_RST;
    end else if (wr_fire) begin
      case (aw_idx_reg)
        `DYC_IDX_CTRL: begin
          ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg, `DYC_CTRL_MASK);
        end
        `DYC_IDX_SLOPE: begin
          slope_reg <= merge(slope_reg, w_data_reg, w_strb_reg, `DYC_SLOPE_MASK);
        end
        `DYC_IDX_KNEE1: begin
          knee1_reg <= merge(knee1_reg, w_data_reg, w_strb_reg, `DYC_KNEE1_MASK);
        end
        `DYC_IDX_KNEE2: begin
          knee2_reg <= merge(knee2_reg, w_data_reg, w_strb_reg, `DYC_KNEE2_MASK);
        end
        default: begin
          ctrl_reg <= ctrl_reg;
        end
      endcase
    end
  end

  // Read channel: one read in flight, data registered with the valid
  assign rd_fire = s_axi_arvalid && arready_reg;
  assign rvalid_next = rd_fire || (rvalid_reg && !s_axi_rready);
  assign ar_idx = s_axi_araddr[13:2];

  always_comb begin
    rd_hit = 1'b1;
    case (ar_idx)
      `DYC_IDX_CTRL: rd_value = {16'h0000, ctrl_reg};
      `DYC_IDX_SLOPE: rd_value = {16'h0000, slope_reg};
      `DYC_IDX_KNEE1: rd_value = {16'h0000, knee1_reg};
      `DYC_IDX_KNEE2: rd_value = {16'h0000, knee2_reg};
      `DYC_IDX_STAT: rd_value = {16'h0000, full_scale_out_level, level};
      default: begin
        rd_value = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `DYC_RESP_OKAY;
    end else begin
      arready_reg <= !rvalid_next;
      rvalid_reg <= rvalid_next;
      if (rd_fire) begin
        rdata_reg <= rd_value;
        rresp_reg <= rd_hit ? `DYC_RESP_OKAY : `DYC_RESP_SLVERR;
      end
    end
  end

  // The detector sees only the selected path, so one gain serves one path
  assign path_play = ctrl_reg[`DYC_CTRL_PATH];
  assign gain_on = ctrl_reg[`DYC_CTRL_ENA];
  assign det_valid = path_play ? play_in_valid : rec_in_valid;
  assign det_l = path_play ? play_in_l : rec_in_l;
  assign det_r = path_play ? play_in_r : rec_in_r;

  dyc_level u_level (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .smp_valid(det_valid),
    .smp_l(det_l),
    .smp_r(det_r),
    .level(level),
    .level_valid(level_valid)
  );

  dyc_curve u_curve (
    .level_in(level),
    .first_knee_in_level(knee1_reg[`DYC_KNEE1_IN]),
    .first_knee_out_level(knee1_reg[`DYC_KNEE1_OUT]),
    .upper_region_slope(slope_reg[`DYC_SLOPE_HI]),
    .lower_region_slope(slope_reg[`DYC_SLOPE_LO]),
    .gate_expansion_slope(slope_reg[`DYC_SLOPE_EXP]),
    .second_knee_in_level(knee2_reg[`DYC_KNEE2_IN]),
    .second_knee_out_level(knee2_reg[`DYC_KNEE2_OUT]),
    .noise_gate_enable(ctrl_reg[`DYC_CTRL_GATE]),
    .second_knee_out_enable(ctrl_reg[`DYC_CTRL_K2OUT]),
    .gain(gain_raw),
    .full_scale_out_level(full_scale_out_level)
  );

  // Clamp keeps the shifter small; boost beyond +47 dB saturates anyway
  always_comb begin
    if (gain_raw < $signed(`DYC_GAIN_MIN)) begin
      gain_clamped = $signed(`DYC_GAIN_MIN);
    end else if (gain_raw > $signed(`DYC_GAIN_MAX)) begin
      gain_clamped = $signed(`DYC_GAIN_MAX);
    end else begin
      gain_clamped = gain_raw;
    end
  end

  assign in_valid = {play_in_valid, rec_in_valid};
  assign ch_in[0] = rec_in_l;
  assign ch_in[1] = rec_in_r;
  assign ch_in[2] = play_in_l;
  assign ch_in[3] = play_in_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      vld_d1_reg <= 2'b00;
      out_valid_reg <= 2'b00;
    end else begin
      vld_d1_reg <= in_valid;
      out_valid_reg <= vld_d1_reg;
    end
  end

  // Both paths see the same two-cycle latency whether gain acts or not
  for (genvar c = 0; c < 4; c++) begin : g_chan
    localparam int P = c / 2;
    localparam logic [127:0] MANT_TABLE = `DYC_MANT_TABLE;
    logic [15:0] mant;
    logic signed [47:0] prod;
    logic signed [47:0] scaled;
    logic signed [5:0] gi;
    logic apply;
    assign gi = gain_clamped[8:3];
    assign mant = MANT_TABLE[{gain_clamped[2:0], 4'h0} +: 16];
    assign prod = 48'(ch_hold_reg[c]) * 48'($signed({1'b0, mant}));
    assign scaled = gi[5] ? (prod >>> (`DYC_MANT_FRAC + 6'(-gi)))
                          : ((prod <<< 6'(gi)) >>> `DYC_MANT_FRAC);
    assign apply = gain_on && (path_play == P[0]);

    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        ch_hold_reg[c] <= 24'sh00_0000;
        ch_out_reg[c] <= 24'sh00_0000;
      end else begin
        if (in_valid[P]) begin
          ch_hold_reg[c] <= ch_in[c];
        end
        if (vld_d1_reg[P]) begin
          if (!apply) begin
            ch_out_reg[c] <= ch_hold_reg[c];
          end else if (scaled > 48'sh7F_FFFF) begin
            ch_out_reg[c] <= 24'sh7F_FFFF;
          end else if (scaled < -48'sh80_0000) begin
            ch_out_reg[c] <= 24'sh80_0000;
          end else begin
            ch_out_reg[c] <= scaled[23:0];
          end
        end
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rec_out_valid = out_valid_reg[0];
  assign play_out_valid = out_valid_reg[1];
  assign rec_out_l = ch_out_reg[0];
  assign rec_out_r = ch_out_reg[1];
  assign play_out_l = ch_out_reg[2];
  assign play_out_r = ch_out_reg[3];
endmodule

// [sim/dyc_src.sv]
`timescale 1ns/1ps
module dyc_src
  import dyc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Sample stream towards the block
  output logic vld,
  output dyc_sample_t l,
  output dyc_sample_t r
);
  initial begin
    vld = 1'b0;
    l = '0;
    r = '0;
  end
  // One stereo sample, then a quiet cycle; back-to-back pushes land three cycles apart
  task automatic push(input dyc_sample_t a, input dyc_sample_t b);
    @(posedge sys_clk);
    vld <= 1'b1;
    l <= a;
    r <= b;
    @(posedge sys_clk);
    vld <= 1'b0;
    // Stale data is inverted so a late capture cannot pass by luck
    l <= ~a;
    r <= ~b;
    @(posedge sys_clk);
  endtask
endmodule

// [sim/dyc_compressor_asserts.sv]
`timescale 1ns/1ps
`include "dyc_cfg.svh"
module dyc_compressor_asserts
  import dyc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Register bus
  input wire logic [15:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [15:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  // Sample streams
  input wire logic rec_in_valid,
  input wire logic rec_out_valid,
  input wire dyc_sample_t rec_out_l,
  input wire logic play_in_valid,
  input wire logic play_out_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  function automatic logic bad(input logic [15:0] a);
    bad = !(a[13:2] inside {`DYC_IDX_CTRL, `DYC_IDX_SLOPE, `DYC_IDX_KNEE1,
                            `DYC_IDX_KNEE2, `DYC_IDX_STAT});
  endfunction
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_take |-> ##2 s_axi_bvalid;
  endproperty
  property p_wr_hold;
    s_wr_take |=> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_wr_bad;
    (s_wr_take ##0 bad(s_axi_awaddr)) |-> ##2 s_axi_bresp == `DYC_RESP_SLVERR;
  endproperty
  property p_b_clear;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_take |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rd_bad;
    (s_rd_take ##0 bad(s_axi_araddr)) |=> s_axi_rresp == `DYC_RESP_SLVERR && s_axi_rdata == 0;
  endproperty
  property p_rec_lat;
    rec_in_valid |-> ##2 rec_out_valid;
  endproperty
  property p_play_lat;
    play_in_valid |-> ##2 play_out_valid;
  endproperty
  property p_rec_only;
    rec_out_valid |-> $past(rec_in_valid, 2);
  endproperty
  property p_rec_hold;
    !rec_out_valid |-> $stable(rec_out_l);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  a_wr_hold: assert property (p_wr_hold) else $error("write ready not dropped");
  a_wr_bad: assert property (p_wr_bad) else $error("unmapped write not refused");
  a_b_clear: assert property (p_b_clear) else $error("write answer stuck");
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
  a_rec_lat: assert property (p_rec_lat) else $error("record output late");
  a_play_lat: assert property (p_play_lat) else $error("playback output late");
  a_rec_only: assert property (p_rec_only) else $error("record output unprompted");
  a_rec_hold: assert property (p_rec_hold) else $error("record output moved");
endmodule
bind dyc_compressor dyc_compressor_asserts u_dyc_compressor_asserts (
  .sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .rec_in_valid(rec_in_valid), .rec_out_valid(rec_out_valid), .rec_out_l(rec_out_l),
  .play_in_valid(play_in_valid), .play_out_valid(play_out_valid));

// [sim/dyc_compressor_tb.sv]
`timescale 1ns/1ps
`include "dyc_cfg.svh"
module dyc_compressor_tb
  import dyc_pkg::*;
;
  localparam logic [15:0] A_CTRL = {2'b00, `DYC_IDX_CTRL, 2'b00};
  localparam logic [15:0] A_SLP = {2'b00, `DYC_IDX_SLOPE, 2'b00};
  localparam logic [15:0] A_K1 = {2'b00, `DYC_IDX_KNEE1, 2'b00};
  localparam logic [15:0] A_K2 = {2'b00, `DYC_IDX_KNEE2, 2'b00};
  localparam logic [15:0] A_ST = {2'b00, `DYC_IDX_STAT, 2'b00};
  localparam logic [15:0] A_BAD = 16'h0454;
  // Quiet enough that the measured level sits at the floor
  localparam dyc_sample_t Q = 24'h00_0100;
  logic sys_clk, rstn;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, bres, rres;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic rec_in_valid, rec_out_valid, play_in_valid, play_out_valid;
  dyc_sample_t rec_in_l, rec_in_r, rec_out_l, rec_out_r, y;
  dyc_sample_t play_in_l, play_in_r, play_out_l, play_out_r;
  int error_cnt, cmp_count, cyc;

  dyc_compressor u_dyc_compressor (.sys_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rec_in_valid, .rec_in_l, .rec_in_r,
    .rec_out_valid, .rec_out_l, .rec_out_r, .play_in_valid, .play_in_l, .play_in_r,
    .play_out_valid, .play_out_l, .play_out_r);
  dyc_src rec_src (.sys_clk, .vld(rec_in_valid), .l(rec_in_l), .r(rec_in_r));
  dyc_src play_src (.sys_clk, .vld(play_in_valid), .l(play_in_l), .r(play_in_r));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic print_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      error_cnt++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bres = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rdat = s_axi_rdata;
    rres = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Send one sample; k: 0 passes unchanged, 1 comes out louder, 2 quieter
  task automatic sr(input bit pb, input dyc_sample_t x, input int k);
    dyc_sample_t yr;
    if (pb) play_src.push(x, x);
    else rec_src.push(x, x);
    repeat (2) @(posedge sys_clk);
    y = pb ? play_out_l : rec_out_l;
    yr = pb ? play_out_r : rec_out_r;
    // Both channels carry the same sample, so both must follow the one expectation
    if (k == 0) begin
      check(32'(y), 32'(x));
      check(32'(yr), 32'(x));
    end else begin
      check(32'(k == 1 ? y > x : y < x), 32'h0000_0001);
      check(32'(k == 1 ? yr > x : yr < x), 32'h0000_0001);
    end
  endtask

  task automatic t_regs;
    logic [15:0] a[4] = '{A_CTRL, A_SLP, A_K1, A_K2};
    logic [31:0] m[4] = '{32'h0000_0093, 32'h0000_00FF, 32'h0000_07FF, 32'h0000_03FF};
    logic [31:0] r0[4] = '{32'h0000_0000, 32'h0000_0018, 32'h0000_0000, 32'h0000_0000};
    rd(A_ST);
    check(rdat, 32'(`DYC_LEVEL_FLOOR));
    for (int i = 0; i < 4; i++) begin
      rd(a[i]);
      check(rdat, r0[i]);
      wr(a[i], 32'hFFFF_FFFF);
      rd(a[i]);
      check(rdat, m[i]);
    end
    rd(A_BAD);
    check(32'(rres), 32'(`DYC_RESP_SLVERR));
    check(rdat, 32'h0000_0000);
    wr(A_BAD, 32'hFFFF_FFFF);
    check(32'(bres), 32'(`DYC_RESP_SLVERR));
    wr(A_ST, 32'hFFFF_FFFF);
    check(32'(bres), 32'(`DYC_RESP_OKAY));
  endtask

  task automatic t_fs;
    int e;
    wr(A_CTRL, 32'h0000_0000);
    wr(A_K1, 32'h0000_0410);
    for (int c = 0; c < 8; c++) begin
      wr(A_SLP, 32'(c << 3));
      rd(A_ST);
      e = (c == 5) ? 16 : (c > 5) ? -16 : 16 - (32 >> c);
      check(32'(rdat[15:8]), 32'(e[7:0]));
    end
  endtask

  task automatic t_path;
    wr(A_K1, 32'h0000_0000);
    wr(A_K2, 32'h0000_0000);
    wr(A_SLP, 32'h0000_0004);
    wr(A_CTRL, 32'h0000_0002);
    sr(0, Q, 0);
    sr(1, Q, 0);
    wr(A_CTRL, 32'h0000_0003);
    sr(0, Q, 0);
    sr(1, Q, 1);
    wr(A_CTRL, 32'h0000_0001);
    sr(0, Q, 1);
    sr(1, Q, 0);
  endtask

  task automatic t_lo;
    for (int c = 0; c < 8; c++) begin
      wr(A_SLP, 32'(c));
      sr(0, Q, (c >= 1 && c <= 4) ? 1 : 0);
    end
  endtask

  task automatic t_gate;
    logic [31:0] ct[5] = '{32'h0000_0001, 32'h0000_0081, 32'h0000_0081, 32'h0000_0091,
                           32'h0000_0011};
    logic [31:0] sl[5] = '{32'h0000_00C0, 32'h0000_0000, 32'h0000_0040, 32'h0000_0000,
                           32'h0000_0000};
    int k[5] = '{0, 0, 2, 1, 0};
    for (int i = 0; i < 5; i++) begin
      wr(A_CTRL, ct[i]);
      wr(A_SLP, sl[i]);
      sr(0, Q, k[i]);
    end
  endtask

  task automatic t_avg;
    wr(A_CTRL, 32'h0000_0001);
    wr(A_SLP, 32'h0000_0000);
    sr(0, 24'h40_0000, 0);
    rd(A_ST);
    // A peak follower would already read about 8 here
    check(32'(rdat[7:0] > 8'h14), 32'h0000_0001);
    repeat (300) rec_src.push(24'h40_0000, 24'h40_0000);
    rd(A_ST);
    check(32'(rdat[7:0] < 8'h0C), 32'h0000_0001);
  endtask

  initial begin
    rstn = 1'b0;
    s_axi_awaddr = '0;
    s_axi_araddr = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'b0011;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge sys_clk);
    t_regs();
    t_fs();
    t_path();
    t_lo();
    t_gate();
    t_avg();
    print_verdict();
  end
endmodule
